// ===== rtl/dprmc_defines.svh
// constants for the repeater mode controller: offsets, fields, reset values, timing
`ifndef DPRMC_DEFINES_SVH
`define DPRMC_DEFINES_SVH

// ----------------------------------------------------------------
// shadowed link configuration addresses and reset values
// ----------------------------------------------------------------
`define DPRMC_ADDR_LANE_CNT 20'h00101
`define DPRMC_ADDR_LANE_SET 20'h00103
`define DPRMC_LANE_CNT_RST 8'h00
`define DPRMC_LANE_SET_RST 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DPRMC_LANE_MSB 4
`define DPRMC_SWING_MSB 1
`define DPRMC_SWING_LSB 0
`define DPRMC_PREEMPH_MSB 4
`define DPRMC_PREEMPH_LSB 3

// ----------------------------------------------------------------
// fixed settings and timing
// ----------------------------------------------------------------
`define DPRMC_SWING_600MV 2'h1
`define DPRMC_TMDS_LANES 5'h04
`define DPRMC_CLK_PERIOD_NS 40
`define DPRMC_PLUG_LOSS_NS 2000
`define DPRMC_PLUG_LOSS_CYC ((`DPRMC_PLUG_LOSS_NS + `DPRMC_CLK_PERIOD_NS - 1) / `DPRMC_CLK_PERIOD_NS)

`endif

// ===== rtl/dprmc_pkg.sv
// types shared by the repeater mode controller
package dprmc_pkg;
	// internal operating state
	typedef enum logic [1:0] {M_SHUTDOWN, M_STANDBY, M_D3, M_ACTIVE} dprmc_mode_t;
	// reported mode, output disable shown over the base state
	typedef enum logic [2:0] {ST_SHUTDOWN, ST_STANDBY, ST_D3, ST_ACTIVE, ST_OUTDIS} dprmc_status_t;
endpackage

// ===== rtl/dprmc_plug_filter.sv
// plug-loss filter: flags a plug-detect input held low past the filter time
`include "dprmc_defines.svh"
module dprmc_plug_filter #(
	parameter int unsigned LOSS_CYCLES = `DPRMC_PLUG_LOSS_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic plug_in,
	output logic lost,
	output logic rise
);
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic lost_r;
	logic lost_nxt;
	logic prev_r;
	localparam logic [15:0] LOSS_CNT = LOSS_CYCLES[15:0];

	// ----------------------------------------------------------------
	// low-time counter
	// ----------------------------------------------------------------
	// restart on high
	always_comb
	begin
		cnt_nxt = cnt_r;
		lost_nxt = lost_r;
		if (plug_in)
		begin
			cnt_nxt = 16'h0000;
			lost_nxt = 1'b0;
		end
		else if (cnt_r != LOSS_CNT)
			cnt_nxt = cnt_r + 16'h0001; // saturates, so a long unplug never wraps
		else
			lost_nxt = 1'b1;
	end

	// registers; prev starts low so a plug already present after reset counts as a rise
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_r <= 16'h0000;
			lost_r <= 1'b0;
			prev_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			lost_r <= lost_nxt;
			prev_r <= plug_in;
		end
	end

	assign lost = lost_r;
	assign rise = plug_in & ~prev_r;

	restart_cnt_a: assert property (@(posedge clk) disable iff (rst) plug_in |=> cnt_r == 16'h0000 && !lost_r)
		else $error("loss counter not restarted by high plug detect");
endmodule // dprmc_plug_filter

// ===== rtl/dprmc_mode_ctrl.sv
// operating-mode controller of a dual-mode display repeater
// ----------------------------------------------------------------
// Summary of operation
// - shutdown pin low: plug detect passes through, other outputs off, inputs ignored
// - shutdown holds shadow registers and control logic at reset defaults
// - standby when plug detect low past loss filter; link off, aux watched
// - d3 entry command disables main link in and out, aux stays watched
// - active while plug high; short low pulses do not leave active
// - adapter detect high selects tmds mode, low selects displayport mode
// - displayport mode takes swing, equalization and lanes from snooped training
// - displayport mode keeps main link outputs off until training writes enabling values
// - tmds mode fixes 600 mV swing and ignores all aux traffic
// - each snooped configuration write updates the local shadow copy
// - invalid value written at dpcd_shadow_101 or dpcd_shadow_103 disables main link outputs
// - output disable applies only while enable is high and entry invalid
// - once all shadows valid again, the normal mode resumes
// - d3 exits to active on exit command or plug detect rising
// - shutdown pin rising enters standby and starts aux watching
// ----------------------------------------------------------------
`include "dprmc_defines.svh"
module dprmc_mode_ctrl #(
	parameter int unsigned PLUG_LOSS_CYCLES = `DPRMC_PLUG_LOSS_CYC
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic SHUTDOWN_N_PIN,
	input wire logic PLUG_DETECT_IN,
	input wire logic ADAPTER_DETECT_IN,
	input wire logic EN,
	input wire logic DPCD_WR_STB,
	input wire logic [19:0] DPCD_WR_ADDR,
	input wire logic [7:0] DPCD_WR_DATA,
	input wire logic AUX_D3_ENTER,
	input wire logic AUX_D3_EXIT,
	output logic PLUG_DETECT_OUT,
	output logic MAIN_LINK_OUT_EN,
	output logic MAIN_LINK_IN_EN,
	output logic AUX_MON_EN,
	output logic TMDS_MODE,
	output logic [1:0] SWING_LEVEL,
	output logic [1:0] EQ_LEVEL,
	output logic [4:0] LANE_COUNT,
	output dprmc_pkg::dprmc_status_t MODE_STATUS,
	output logic [7:0] SHADOW_101,
	output logic [7:0] SHADOW_103
);
	import dprmc_pkg::*;

	logic logic_rst;
	logic plug_lost;
	logic plug_rise;
	logic tmds;
	logic lane_bad;
	logic set_bad;
	logic out_dis;
	logic [2:0] level_sum;
	logic [7:0] shadow_r [2];
	logic [7:0] shadow_nxt [2];
	dprmc_mode_t mode_r;
	dprmc_mode_t mode_nxt;
	logic out_en_r, out_en_nxt, in_en_r, in_en_nxt, aux_r, aux_nxt, tmds_r, plug_out_r;
	logic [1:0] swing_r, swing_nxt, eq_r, eq_nxt;
	logic [4:0] lanes_r, lanes_nxt;
	dprmc_status_t status_r, status_nxt;
	localparam logic [19:0] SHADOW_ADDR [2] = '{`DPRMC_ADDR_LANE_CNT, `DPRMC_ADDR_LANE_SET};
	localparam logic [7:0] SHADOW_RST [2] = '{`DPRMC_LANE_CNT_RST, `DPRMC_LANE_SET_RST};

	// ----------------------------------------------------------------
	// shutdown and mode selection
	// ----------------------------------------------------------------
	// shutdown holds reset
	assign logic_rst = RST | ~SHUTDOWN_N_PIN;
	assign tmds = ADAPTER_DETECT_IN;

	dprmc_plug_filter #(
		.LOSS_CYCLES(PLUG_LOSS_CYCLES)
	) u_plug_filter (
		.clk(CLK),
		.rst(logic_rst),
		.plug_in(PLUG_DETECT_IN),
		.lost(plug_lost),
		.rise(plug_rise)
	);

	// ----------------------------------------------------------------
	// shadow copies of the snooped link configuration
	// ----------------------------------------------------------------
	genvar g;
	for (g = 0; g < 2; g++)
	begin : g_shadow
		always_comb
		begin
			shadow_nxt[g] = shadow_r[g];
			if (DPCD_WR_STB && !tmds && DPCD_WR_ADDR == SHADOW_ADDR[g])
				shadow_nxt[g] = DPCD_WR_DATA;
		end

		// invalid entries are stored too; the disable holds until a valid rewrite
		always_ff @(posedge CLK)
		begin
			if (logic_rst)
				shadow_r[g] <= SHADOW_RST[g];
			else
				shadow_r[g] <= shadow_nxt[g];
		end
	end

	// disable lifts once both valid
	// lane count must be 0, 1, 2 or 4; swing plus pre-emphasis may not pass level 3
	assign lane_bad = !(shadow_r[0][`DPRMC_LANE_MSB:0] inside {5'h00, 5'h01, 5'h02, 5'h04}) ||
		shadow_r[0][7:5] != 3'h0;
	assign level_sum = {1'b0, shadow_r[1][`DPRMC_SWING_MSB:`DPRMC_SWING_LSB]} +
		{1'b0, shadow_r[1][`DPRMC_PREEMPH_MSB:`DPRMC_PREEMPH_LSB]};
	assign set_bad = level_sum > 3'h3;
	assign out_dis = EN & (lane_bad | set_bad);

	// ----------------------------------------------------------------
	// operating state
	// ----------------------------------------------------------------
	always_comb
	begin
		mode_nxt = mode_r;
		unique case (mode_r)
			M_SHUTDOWN: mode_nxt = M_STANDBY;
			M_STANDBY:
				if (PLUG_DETECT_IN)
					mode_nxt = M_ACTIVE;
			M_ACTIVE:
				if (plug_lost)
					mode_nxt = M_STANDBY;
				else if (AUX_D3_ENTER && !tmds)
					mode_nxt = M_D3;
			M_D3:
				if (plug_lost)
					mode_nxt = M_STANDBY;
				else if ((AUX_D3_EXIT && !tmds) || plug_rise)
					mode_nxt = M_ACTIVE;
		endcase
	end

	// short lows tolerated: only the filtered loss or a d3 entry leaves active
	always_ff @(posedge CLK)
	begin
		if (logic_rst)
			mode_r <= M_SHUTDOWN;
		else
			mode_r <= mode_nxt;
	end

	// ----------------------------------------------------------------
	// output controls
	// ----------------------------------------------------------------
	always_comb
	begin
		out_en_nxt = mode_r == M_ACTIVE && !out_dis && (tmds || shadow_r[0][`DPRMC_LANE_MSB:0] != 5'h00);
		in_en_nxt = mode_r == M_ACTIVE;
		aux_nxt = mode_r != M_SHUTDOWN && !tmds;
		swing_nxt = shadow_r[1][`DPRMC_SWING_MSB:`DPRMC_SWING_LSB];
		eq_nxt = shadow_r[1][`DPRMC_PREEMPH_MSB:`DPRMC_PREEMPH_LSB];
		lanes_nxt = shadow_r[0][`DPRMC_LANE_MSB:0];
		if (tmds)
		begin
			swing_nxt = `DPRMC_SWING_600MV;
			eq_nxt = 2'h0;
			lanes_nxt = `DPRMC_TMDS_LANES;
		end
		if (out_dis && mode_r != M_SHUTDOWN)
			status_nxt = ST_OUTDIS;
		else
			status_nxt = dprmc_status_t'({1'b0, mode_r});
	end

	always_ff @(posedge CLK)
	begin
		if (logic_rst)
		begin
			out_en_r <= 1'b0;
			in_en_r <= 1'b0;
			aux_r <= 1'b0;
			tmds_r <= 1'b0;
			swing_r <= 2'h0;
			eq_r <= 2'h0;
			lanes_r <= 5'h00;
			status_r <= ST_SHUTDOWN;
		end
		else
		begin
			out_en_r <= out_en_nxt;
			in_en_r <= in_en_nxt;
			aux_r <= aux_nxt;
			tmds_r <= tmds;
			swing_r <= swing_nxt;
			eq_r <= eq_nxt;
			lanes_r <= lanes_nxt;
			status_r <= status_nxt;
		end
	end

	// plug detect passes through in every mode, shutdown included
	always_ff @(posedge CLK)
	begin
		if (RST)
			plug_out_r <= 1'b0;
		else
			plug_out_r <= PLUG_DETECT_IN;
	end

	assign PLUG_DETECT_OUT = plug_out_r;
	assign MAIN_LINK_OUT_EN = out_en_r;
	assign MAIN_LINK_IN_EN = in_en_r;
	assign AUX_MON_EN = aux_r;
	assign TMDS_MODE = tmds_r;
	assign SWING_LEVEL = swing_r;
	assign EQ_LEVEL = eq_r;
	assign LANE_COUNT = lanes_r;
	assign MODE_STATUS = status_r;
	assign SHADOW_101 = shadow_r[0];
	assign SHADOW_103 = shadow_r[1];

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	plug_pass_a: assert property (1'b1 |=> PLUG_DETECT_OUT == $past(PLUG_DETECT_IN))
		else $error("plug detect output does not follow input");
	shutdown_off_a: assert property (!SHUTDOWN_N_PIN |=> !MAIN_LINK_OUT_EN && !AUX_MON_EN && !MAIN_LINK_IN_EN)
		else $error("outputs active during shutdown");
	shadow_reset_a: assert property (!SHUTDOWN_N_PIN
		|=> shadow_r[0] == `DPRMC_LANE_CNT_RST && shadow_r[1] == `DPRMC_LANE_SET_RST)
		else $error("shadow not held at reset in shutdown");
	standby_entry_a: assert property ($rose(SHUTDOWN_N_PIN) |=> mode_r == M_STANDBY)
		else $error("shutdown release did not enter standby");
	loss_standby_a: assert property (mode_r == M_ACTIVE && plug_lost && SHUTDOWN_N_PIN |=> mode_r == M_STANDBY)
		else $error("plug loss did not enter standby");
	d3_entry_a: assert property (mode_r == M_ACTIVE && !plug_lost && AUX_D3_ENTER && !tmds && SHUTDOWN_N_PIN
		|=> mode_r == M_D3 ##1 !MAIN_LINK_OUT_EN && !MAIN_LINK_IN_EN)
		else $error("d3 entry did not disable main link");
	active_hold_a: assert property (mode_r == M_ACTIVE && !plug_lost && !AUX_D3_ENTER && SHUTDOWN_N_PIN
		|=> mode_r == M_ACTIVE)
		else $error("active left without filtered loss");
	d3_exit_a: assert property (mode_r == M_D3 && !plug_lost && plug_rise && SHUTDOWN_N_PIN |=> mode_r == M_ACTIVE)
		else $error("plug rise did not leave d3");
	tmds_swing_a: assert property (tmds && SHUTDOWN_N_PIN |=> TMDS_MODE && SWING_LEVEL == `DPRMC_SWING_600MV)
		else $error("tmds swing not fixed");
	tmds_ignore_a: assert property (tmds && SHUTDOWN_N_PIN |=> shadow_r[1] == $past(shadow_r[1]))
		else $error("aux write taken in tmds mode");
	snoop_write_a: assert property (DPCD_WR_STB && !tmds && SHUTDOWN_N_PIN && DPCD_WR_ADDR == `DPRMC_ADDR_LANE_SET
		|=> shadow_r[1] == $past(DPCD_WR_DATA))
		else $error("snooped write not copied");
	train_levels_a: assert property (!tmds && SHUTDOWN_N_PIN |=> SWING_LEVEL == $past(shadow_r[1][1:0])
		&& LANE_COUNT == $past(shadow_r[0][4:0]))
		else $error("levels not taken from training");
	lanes_off_a: assert property (!tmds && shadow_r[0][4:0] == 5'h00 |=> !MAIN_LINK_OUT_EN)
		else $error("outputs on before training");
	out_disable_a: assert property (out_dis && SHUTDOWN_N_PIN |=> !MAIN_LINK_OUT_EN && MODE_STATUS == ST_OUTDIS)
		else $error("invalid entry did not disable outputs");
	en_gate_a: assert property (!EN && mode_r == M_ACTIVE && !tmds && lanes_nxt != 5'h00 && SHUTDOWN_N_PIN
		|=> MAIN_LINK_OUT_EN)
		else $error("outputs disabled while enable low");
	recover_a: assert property (mode_r == M_ACTIVE && !out_dis && !tmds && lanes_nxt != 5'h00
		&& SHUTDOWN_N_PIN |=> MAIN_LINK_OUT_EN && MODE_STATUS == ST_ACTIVE)
		else $error("valid entries did not restore mode");

	reach_d3_c: cover property (mode_r == M_ACTIVE ##1 mode_r == M_D3 ##[1:20] mode_r == M_ACTIVE);
	out_dis_c: cover property (MAIN_LINK_OUT_EN ##1 out_dis ##[1:20] MAIN_LINK_OUT_EN);
	tmds_active_c: cover property (TMDS_MODE && MAIN_LINK_OUT_EN);
	loss_c: cover property (mode_r == M_ACTIVE ##1 mode_r == M_STANDBY);
endmodule // dprmc_mode_ctrl

// ===== verification/dprmc_aux_src.sv
// aux-side source model: snooped configuration writes and d3 commands
module dprmc_aux_src (
	input wire logic clk,
	output logic stb,
	output logic [19:0] addr,
	output logic [7:0] data,
	output logic d3_in,
	output logic d3_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// aux command drivers
	// ----------------------------------------------------------------
	initial
	begin
		stb = 1'b0;
		addr = 20'h00000;
		data = 8'h00;
		d3_in = 1'b0;
		d3_out = 1'b0;
	end
	// whole write, retrain
	// released lines show the inverse so a stale value never looks valid
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		@(posedge clk);
		stb <= 1'b1;
		addr <= a;
		data <= d;
		@(posedge clk);
		stb <= 1'b0;
		addr <= ~a;
		data <= ~d;
	endtask
	// one-cycle decoded d3 command, exit when ex is high
	task automatic d3(input logic ex);
		@(posedge clk);
		if (ex)
			d3_out <= 1'b1;
		else
			d3_in <= 1'b1;
		@(posedge clk);
		d3_in <= 1'b0;
		d3_out <= 1'b0;
	endtask
endmodule // dprmc_aux_src

// ===== verification/tb_dprmc_mode_ctrl.sv
// testbench of the repeater mode controller
module tb_dprmc_mode_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import dprmc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sd_n = 1'b0;
	logic plug = 1'b0;
	logic adp = 1'b0;
	logic en = 1'b0;
	logic stb, d3i, d3o, p_out, o_en, i_en, aux, tmds;
	logic [19:0] wa;
	logic [7:0] wd, s101, s103;
	logic [1:0] swing, eq;
	logic [4:0] lane;
	dprmc_status_t mst;
	int n_errors = 0;
	int total_checks = 0;
	// 25 MHz clock
	always #20 clk = ~clk;
	dprmc_aux_src i_src (.clk(clk), .stb(stb), .addr(wa), .data(wd), .d3_in(d3i), .d3_out(d3o));
	// short loss filter keeps the run small
	dprmc_mode_ctrl #(.PLUG_LOSS_CYCLES(4)) i_dut (.CLK(clk), .RST(rst), .SHUTDOWN_N_PIN(sd_n),
		.PLUG_DETECT_IN(plug), .ADAPTER_DETECT_IN(adp), .EN(en), .DPCD_WR_STB(stb), .DPCD_WR_ADDR(wa),
		.DPCD_WR_DATA(wd), .AUX_D3_ENTER(d3i), .AUX_D3_EXIT(d3o), .PLUG_DETECT_OUT(p_out),
		.MAIN_LINK_OUT_EN(o_en), .MAIN_LINK_IN_EN(i_en), .AUX_MON_EN(aux), .TMDS_MODE(tmds),
		.SWING_LEVEL(swing), .EQ_LEVEL(eq), .LANE_COUNT(lane), .MODE_STATUS(mst),
		.SHADOW_101(s101), .SHADOW_103(s103));
	// ----------------------------------------------------------------
	// compare and sequencing helpers
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chkst(input dprmc_status_t e);
		total_checks++;
		if (mst !== e)
		begin
			n_errors++;
			$display("mismatch MODE_STATUS exp %0d got %0d", e, mst);
		end
	endtask
	// wait n edges, then settle past the edge
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// plug detect low for n sampled cycles
	task automatic pulse(input int n);
		@(posedge clk) plug <= 1'b0;
		repeat (n) @(posedge clk);
		plug <= 1'b1;
		#1;
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// watchdog far beyond the roughly 120 cycles the tests need
	initial
	begin
		#40000;
		n_errors++;
		print_verdict();
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk) plug <= 1'b1;
		w(3);
		chk("PLUG_DETECT_OUT", 8'h01, {7'h00, p_out});
		chkst(ST_SHUTDOWN);
		chk("AUX_MON_EN", 8'h00, {7'h00, aux});
		i_src.wr(20'h00101, 8'h02);
		w(2);
		chk("SHADOW_101", 8'h00, s101);
		@(posedge clk) plug <= 1'b0;
		sd_n <= 1'b1;
		w(3);
		chkst(ST_STANDBY);
		chk("AUX_MON_EN", 8'h01, {7'h00, aux});
		chk("MAIN_LINK_IN_EN", 8'h00, {7'h00, i_en});
		chk("PLUG_DETECT_OUT", 8'h00, {7'h00, p_out});
		@(posedge clk) plug <= 1'b1;
		w(3);
		chkst(ST_ACTIVE);
		chk("MAIN_LINK_IN_EN", 8'h01, {7'h00, i_en});
		chk("MAIN_LINK_OUT_EN", 8'h00, {7'h00, o_en});
		i_src.wr(20'h00101, 8'h02);
		i_src.wr(20'h00103, 8'h09);
		w(3);
		chk("SHADOW_101", 8'h02, s101);
		chk("SHADOW_103", 8'h09, s103);
		chk("LANE_COUNT", 8'h02, {3'h0, lane});
		chk("SWING_LEVEL", 8'h01, {6'h00, swing});
		chk("EQ_LEVEL", 8'h01, {6'h00, eq});
		chk("MAIN_LINK_OUT_EN", 8'h01, {7'h00, o_en});
		chk("TMDS_MODE", 8'h00, {7'h00, tmds});
		// two short drops with one high sample between: counter must restart
		pulse(3);
		pulse(3);
		w(3);
		chkst(ST_ACTIVE);
		pulse(8);
		chkst(ST_STANDBY);
		w(3);
		chkst(ST_ACTIVE);
		i_src.d3(1'b0);
		w(3);
		chkst(ST_D3);
		chk("MAIN_LINK_IN_EN", 8'h00, {7'h00, i_en});
		chk("MAIN_LINK_OUT_EN", 8'h00, {7'h00, o_en});
		chk("AUX_MON_EN", 8'h01, {7'h00, aux});
		i_src.d3(1'b1);
		w(3);
		chkst(ST_ACTIVE);
		i_src.d3(1'b0);
		w(3);
		pulse(2);
		w(3);
		chkst(ST_ACTIVE);
		@(posedge clk) en <= 1'b1;
		w(3);
		chkst(ST_ACTIVE);
		i_src.wr(20'h00101, 8'h03);
		w(3);
		chkst(ST_OUTDIS);
		chk("MAIN_LINK_OUT_EN", 8'h00, {7'h00, o_en});
		@(posedge clk) en <= 1'b0;
		w(3);
		chkst(ST_ACTIVE);
		@(posedge clk) en <= 1'b1;
		w(3);
		chkst(ST_OUTDIS);
		i_src.wr(20'h00101, 8'h02);
		w(3);
		chkst(ST_ACTIVE);
		i_src.wr(20'h00103, 8'h1B);
		w(3);
		chkst(ST_OUTDIS);
		i_src.wr(20'h00103, 8'h09);
		w(3);
		chkst(ST_ACTIVE);
		chk("MAIN_LINK_OUT_EN", 8'h01, {7'h00, o_en});
		@(posedge clk) adp <= 1'b1;
		w(3);
		chk("TMDS_MODE", 8'h01, {7'h00, tmds});
		chk("SWING_LEVEL", 8'h01, {6'h00, swing});
		chk("LANE_COUNT", 8'h04, {3'h0, lane});
		chk("EQ_LEVEL", 8'h00, {6'h00, eq});
		chk("AUX_MON_EN", 8'h00, {7'h00, aux});
		i_src.wr(20'h00101, 8'h01);
		i_src.d3(1'b0);
		w(3);
		chk("SHADOW_101", 8'h02, s101);
		chkst(ST_ACTIVE);
		@(posedge clk) sd_n <= 1'b0;
		w(3);
		chkst(ST_SHUTDOWN);
		chk("SHADOW_101", 8'h00, s101);
		chk("SHADOW_103", 8'h00, s103);
		chk("MAIN_LINK_OUT_EN", 8'h00, {7'h00, o_en});
		chk("TMDS_MODE", 8'h00, {7'h00, tmds});
		print_verdict();
	end
endmodule // tb_dprmc_mode_ctrl
